// ==== design/uart_banked_register_file.sv ====
// apb register file of two serial ports, each with four banked register sets
// assumes the serial datapath runs on pclk and feeds status without synchronising
`timescale 1ns/1ps
module uart_banked_register_file #(
  parameter logic [7:0] MODULE_REVISION_ID = 8'h21 // arbitrary value
) (
  // apb clock and reset
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  // apb slave
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [uart_regs_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                        pwdata,
  output logic      [31:0]                        prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  // datapath status, index 0 is serial_port_one
  input  wire uart_regs_pkg::port_stat_t [1:0]    port_status,
  // datapath control
  output uart_regs_pkg::port_cfg_t       [1:0]    port_config,
  output uart_regs_pkg::port_strobe_t    [1:0]    port_strobe,
  // interrupt
  output logic                                    irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    uart_regs_pkg::port_cfg_t    [1:0] cfg;
    uart_regs_pkg::port_strobe_t [1:0] strobe;
    logic [31:0]                       rdata;
    logic                              ready;
    logic                              slverr;
    logic [uart_regs_pkg::IRQ_BITS-1:0] irq_status;
    logic [uart_regs_pkg::IRQ_BITS-1:0] irq_mask;
    logic                              irq;
  } state_t;

  state_t cur;
  state_t next_state;

  logic [1:0] bank [2];
  logic       bank_ok [2];

  // ----------------------------------------------------------------
  // one bank decoder per port
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_port
      uart_bank_decode u_decode (
        .select_byte (cur.cfg[g].line_control),
        .bank        (bank[g]),
        .bank_ok     (bank_ok[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // address decode, held stable by the master through the transfer
  // ----------------------------------------------------------------
  logic       hit_ports;
  logic       hit_irq;
  logic       port_idx;
  logic [2:0] reg_idx;
  logic       irq_idx;

  always_comb begin
    hit_ports = (paddr[7:6] == uart_regs_pkg::REGION_PORTS);
    hit_irq   = (paddr[7:3] == uart_regs_pkg::REGION_IRQ);
    port_idx  = paddr[uart_regs_pkg::PORT_SEL_BIT];
    reg_idx   = paddr[4:2];
    irq_idx   = paddr[2];
  end

  // ----------------------------------------------------------------
  // read mux for the addressed port and its active bank
  // ----------------------------------------------------------------
  logic [7:0] port_byte;

  always_comb begin
    uart_regs_pkg::port_cfg_t  c;
    uart_regs_pkg::port_stat_t s;
    c         = cur.cfg[port_idx];
    s         = port_status[port_idx];
    port_byte = uart_regs_pkg::RESET_BYTE;
    if (reg_idx == uart_regs_pkg::IDX_LINE_BANK) begin
      port_byte = c.line_control;
    end else if (bank_ok[port_idx]) begin
      case (bank[port_idx])
        uart_regs_pkg::BANK_0: begin
          case (reg_idx)
            uart_regs_pkg::IDX_DATA:  port_byte = s.receive_data;
            uart_regs_pkg::IDX_ONE:   port_byte = c.interrupt_enable;
            uart_regs_pkg::IDX_TWO:   port_byte = s.event_identification;
            uart_regs_pkg::IDX_FOUR:  port_byte = c.modem_mode_control;
            uart_regs_pkg::IDX_FIVE:  port_byte = s.link_status;
            uart_regs_pkg::IDX_SIX:   port_byte = s.modem_status;
            uart_regs_pkg::IDX_SEVEN: port_byte = c.scratch_aux_status;
            default:                  port_byte = uart_regs_pkg::RESET_BYTE;
          endcase
        end
        uart_regs_pkg::BANK_1: begin
          case (reg_idx)
            uart_regs_pkg::IDX_DATA:  port_byte = c.legacy_divisor_low;
            uart_regs_pkg::IDX_ONE:   port_byte = c.legacy_divisor_high;
            default:                  port_byte = uart_regs_pkg::RESET_BYTE;
          endcase
        end
        uart_regs_pkg::BANK_2: begin
          case (reg_idx)
            uart_regs_pkg::IDX_DATA:  port_byte = c.divisor_low;
            uart_regs_pkg::IDX_ONE:   port_byte = c.divisor_high;
            uart_regs_pkg::IDX_TWO:   port_byte = c.extended_control_one;
            uart_regs_pkg::IDX_FOUR:  port_byte = c.extended_control_two;
            uart_regs_pkg::IDX_SIX:   port_byte = s.tx_fifo_level;
            uart_regs_pkg::IDX_SEVEN: port_byte = s.rx_fifo_level;
            default:                  port_byte = uart_regs_pkg::RESET_BYTE;
          endcase
        end
        uart_regs_pkg::BANK_3: begin
          case (reg_idx)
            uart_regs_pkg::IDX_DATA:  port_byte = MODULE_REVISION_ID;
            uart_regs_pkg::IDX_ONE:   port_byte = c.line_control;
            uart_regs_pkg::IDX_TWO:   port_byte = c.fifo_control;
            default:                  port_byte = uart_regs_pkg::RESET_BYTE;
          endcase
        end
        default: port_byte = uart_regs_pkg::RESET_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic                               setup_hit;
    logic                               done;
    logic                               do_write;
    logic                               do_read;
    logic [7:0]                         wbyte;
    logic [uart_regs_pkg::IRQ_BITS-1:0] events;
    logic [uart_regs_pkg::IRQ_BITS-1:0] clear;
    uart_regs_pkg::port_cfg_t           c;
    setup_hit  = psel && penable && !cur.ready;
    done       = psel && penable && cur.ready;
    do_write   = done && pwrite;
    do_read    = done && !pwrite;
    wbyte      = pwdata[7:0];
    events     = '0;
    clear      = '0;
    c          = cur.cfg[port_idx];
    next_state = cur;

    // strobes last one cycle
    for (int p = 0; p < 2; p++) begin
      next_state.strobe[p].load_tx    = 1'b0;
      next_state.strobe[p].pop_rx     = 1'b0;
      next_state.strobe[p].fifo_write = 1'b0;
    end

    // one wait state: answer prepared in the first access cycle
    next_state.ready  = setup_hit;
    next_state.slverr = setup_hit && !(hit_ports || hit_irq);
    if (setup_hit) begin
      if (pwrite || !(hit_ports || hit_irq)) begin
        next_state.rdata = 32'h0000_0000;
      end else if (hit_irq) begin
        next_state.rdata = 32'h0000_0000;
        next_state.rdata[uart_regs_pkg::IRQ_BITS-1:0] =
          (irq_idx == uart_regs_pkg::IRQ_IDX_STAT) ? cur.irq_status : cur.irq_mask;
      end else begin
        next_state.rdata = {24'h00_0000, port_byte};
      end
    end

    // reading received data pops it from the datapath
    if (do_read && hit_ports && bank_ok[port_idx] && bank[port_idx] == uart_regs_pkg::BANK_0
        && reg_idx == uart_regs_pkg::IDX_DATA
        && cur.cfg[port_idx].line_control[uart_regs_pkg::BANK_EXT_BIT] == 1'b0) begin
      next_state.strobe[port_idx].pop_rx = 1'b1;
    end

    // port register writes take effect at the completing edge only
    if (do_write && hit_ports) begin
      if (reg_idx == uart_regs_pkg::IDX_LINE_BANK) begin
        c.line_control = wbyte;
      end else if (bank_ok[port_idx]) begin
        case (bank[port_idx])
          uart_regs_pkg::BANK_0: begin
            case (reg_idx)
              uart_regs_pkg::IDX_DATA: begin
                next_state.strobe[port_idx].load_tx = 1'b1;
                next_state.strobe[port_idx].tx_data = wbyte;
                events[{port_idx, 1'b0}] = 1'b1;
              end
              uart_regs_pkg::IDX_ONE: c.interrupt_enable = wbyte;
              uart_regs_pkg::IDX_TWO: begin
                c.fifo_control = wbyte;
                next_state.strobe[port_idx].fifo_write = 1'b1;
              end
              uart_regs_pkg::IDX_FOUR:  c.modem_mode_control = wbyte;
              uart_regs_pkg::IDX_SEVEN: c.scratch_aux_status = wbyte;
              default: c = cur.cfg[port_idx];
            endcase
          end
          uart_regs_pkg::BANK_1: begin
            case (reg_idx)
              uart_regs_pkg::IDX_DATA: c.legacy_divisor_low  = wbyte;
              uart_regs_pkg::IDX_ONE:  c.legacy_divisor_high = wbyte;
              default: c = cur.cfg[port_idx];
            endcase
          end
          uart_regs_pkg::BANK_2: begin
            case (reg_idx)
              uart_regs_pkg::IDX_DATA: c.divisor_low          = wbyte;
              uart_regs_pkg::IDX_ONE:  c.divisor_high         = wbyte;
              uart_regs_pkg::IDX_TWO:  c.extended_control_one = wbyte;
              uart_regs_pkg::IDX_FOUR: c.extended_control_two = wbyte;
              // fifo levels are live datapath counts; a write cannot move them
              default: c = cur.cfg[port_idx];
            endcase
          end
          default: c = cur.cfg[port_idx];
        endcase
      end
      next_state.cfg[port_idx] = c;
    end

    // interrupt pair
    if (do_write && hit_irq) begin
      if (irq_idx == uart_regs_pkg::IRQ_IDX_STAT) begin
        clear = pwdata[uart_regs_pkg::IRQ_BITS-1:0];
      end else begin
        next_state.irq_mask = pwdata[uart_regs_pkg::IRQ_BITS-1:0];
      end
    end
    for (int p = 0; p < 2; p++) begin
      if (port_status[p].link_status[uart_regs_pkg::LINK_ERR_BIT]) begin
        events[2*p+1] = 1'b1;
      end
    end
    // a new event beats a clear in the same cycle
    next_state.irq_status = (cur.irq_status & ~clear) | events;
    next_state.irq        = |(next_state.irq_status & next_state.irq_mask);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < 2; p++) begin
        cur.cfg[p]    <= '0;
        cur.strobe[p] <= '0;
      end
      cur.rdata      <= 32'h0000_0000;
      cur.ready      <= 1'b0;
      cur.slverr     <= 1'b0;
      cur.irq_status <= uart_regs_pkg::IRQ_RESET;
      cur.irq_mask   <= uart_regs_pkg::IRQ_RESET;
      cur.irq        <= 1'b0;
    end else begin
      cur <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from state
  // ----------------------------------------------------------------
  assign prdata      = cur.rdata;
  assign pready      = cur.ready;
  assign pslverr     = cur.slverr;
  assign port_config = cur.cfg;
  assign port_strobe = cur.strobe;
  assign irq         = cur.irq;

endmodule : uart_banked_register_file

// ==== design/uart_regs_pkg.sv ====
// constants, field layouts and carrier types for the banked serial port register file
// assumes one apb clock domain; the serial datapath sits outside and talks in port_stat_t
package uart_regs_pkg;

  // ----------------------------------------------------------------
  // register indices inside one port window (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_DATA      = 3'h0;
  localparam logic [2:0] IDX_ONE       = 3'h1;
  localparam logic [2:0] IDX_TWO       = 3'h2;
  localparam logic [2:0] IDX_LINE_BANK = 3'h3;
  localparam logic [2:0] IDX_FOUR      = 3'h4;
  localparam logic [2:0] IDX_FIVE      = 3'h5;
  localparam logic [2:0] IDX_SIX       = 3'h6;
  localparam logic [2:0] IDX_SEVEN     = 3'h7;

  // ----------------------------------------------------------------
  // apb map: port one at 0x00, port two at 0x20, interrupt pair at 0x40
  // ----------------------------------------------------------------
  localparam int         ADDR_W        = 8;
  localparam logic [1:0] REGION_PORTS  = 2'h0;
  localparam logic [4:0] REGION_IRQ    = 5'h08;
  localparam int         PORT_SEL_BIT  = 5;
  localparam logic       IRQ_IDX_STAT  = 1'b0;
  localparam logic       IRQ_IDX_MASK  = 1'b1;

  // ----------------------------------------------------------------
  // bank select fields and patterns
  // ----------------------------------------------------------------
  localparam int         BANK_EXT_BIT  = 7;
  localparam int         BANK_HI_BIT   = 6;
  localparam logic [7:0] BANK2_CODE    = 8'hE0;
  localparam logic [7:0] BANK3_CODE    = 8'hE4;
  localparam logic [1:0] BANK_0        = 2'h0;
  localparam logic [1:0] BANK_1        = 2'h1;
  localparam logic [1:0] BANK_2        = 2'h2;
  localparam logic [1:0] BANK_3        = 2'h3;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE    = 8'h00;
  localparam int         LINK_ERR_BIT  = 7;
  localparam int         IRQ_BITS      = 4;
  localparam logic [3:0] IRQ_RESET     = 4'h0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] interrupt_enable;
    logic [7:0] fifo_control;
    logic [7:0] line_control;
    logic [7:0] modem_mode_control;
    logic [7:0] scratch_aux_status;
    logic [7:0] legacy_divisor_low;
    logic [7:0] legacy_divisor_high;
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic [7:0] extended_control_one;
    logic [7:0] extended_control_two;
  } port_cfg_t;

  typedef struct packed {
    logic [7:0] receive_data;
    logic [7:0] event_identification;
    logic [7:0] link_status;
    logic [7:0] modem_status;
    logic [7:0] tx_fifo_level;
    logic [7:0] rx_fifo_level;
  } port_stat_t;

  typedef struct packed {
    logic       load_tx;
    logic       pop_rx;
    logic       fifo_write;
    logic [7:0] tx_data;
  } port_strobe_t;

endpackage : uart_regs_pkg

// ==== design/uart_bank_decode.sv ====
// bank decoder for one serial port's line control / bank select byte
// assumes the byte comes straight from a register on the same clock
`timescale 1ns/1ps
module uart_bank_decode (
  // select byte
  input  wire logic [7:0] select_byte,
  // decoded bank
  output logic      [1:0] bank,
  output logic            bank_ok
);

  always_comb begin
    bank    = uart_regs_pkg::BANK_0;
    bank_ok = 1'b1;
    if (!select_byte[uart_regs_pkg::BANK_EXT_BIT]) begin
      bank = uart_regs_pkg::BANK_0;
    end else if (!select_byte[uart_regs_pkg::BANK_HI_BIT] || (|select_byte[1:0])) begin
      bank = uart_regs_pkg::BANK_1;
    end else if (select_byte == uart_regs_pkg::BANK2_CODE) begin
      bank = uart_regs_pkg::BANK_2;
    end else if (select_byte == uart_regs_pkg::BANK3_CODE) begin
      bank = uart_regs_pkg::BANK_3;
    end else begin
      // undefined pattern: only the select register itself stays live
      bank_ok = 1'b0;
    end
  end

endmodule : uart_bank_decode

// ==== dv/uart_regs_props.sv ====
// concurrent checks on the ports of the banked serial port register file
// assumes one pclk domain and the one-wait-state apb slave timing
`timescale 1ns/1ps
module uart_regs_props (
  // apb
  input wire logic                            pclk,
  input wire logic                            presetn,
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [uart_regs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                     pwdata,
  input wire logic [31:0]                     prdata,
  input wire logic                            pready,
  input wire logic                            pslverr,
  // datapath side
  input wire uart_regs_pkg::port_stat_t [1:0]   port_status,
  input wire uart_regs_pkg::port_cfg_t [1:0]    port_config,
  input wire uart_regs_pkg::port_strobe_t [1:0] port_strobe,
  input wire logic                            irq
);
  // ------------------------------------------------------------
  // transfer phases
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;  psel && !penable;          endsequence
  sequence s_access; psel && penable && !pready; endsequence
  sequence s_done;   psel && penable && pready;  endsequence
  wire wr_done   = psel && penable && pready && pwrite;
  wire bank0_one = !port_config[0].line_control[7];
  wire bank1_one = port_config[0].line_control[7] && !port_config[0].line_control[6];

  chk_one_wait: assert property (s_setup ##1 s_access |=> s_done)
    else $error("pready not in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_unmapped_err: assert property (s_done |-> (pslverr == (paddr >= 8'h48)))
    else $error("pslverr does not match address map");
  chk_upper_zero: assert property (s_done and !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_load_tx: assert property ((wr_done && bank0_one && paddr == 8'h00) |=>
    port_strobe[0].load_tx && port_strobe[0].tx_data == $past(pwdata[7:0]))
    else $error("transmit load missing");
  chk_fifo_write: assert property ((wr_done && bank0_one && paddr == 8'h08) |=>
    port_strobe[0].fifo_write && port_config[0].fifo_control == $past(pwdata[7:0]))
    else $error("fifo control write missing");
  chk_bank_select: assert property ((wr_done && paddr == 8'h0C) |=>
    port_config[0].line_control == $past(pwdata[7:0]))
    else $error("select byte not stored");
  chk_pop_rx: assert property ((s_done and !pwrite && bank0_one && paddr == 8'h00) |=>
    port_strobe[0].pop_rx ##1 !port_strobe[0].pop_rx)
    else $error("receive pop missing");
  chk_port_apart: assert property ((wr_done && paddr[5] && paddr < 8'h40) |=>
    $stable(port_config[0]))
    else $error("port two write touched port one");
  chk_reserved_ign: assert property ((wr_done && bank1_one && paddr == 8'h08) |=>
    $stable(port_config[0]) && !port_strobe[0].fifo_write)
    else $error("reserved write had an effect");
endmodule : uart_regs_props

bind uart_banked_register_file uart_regs_props i_uart_regs_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_status(port_status), .port_config(port_config), .port_strobe(port_strobe),
  .irq(irq)
);

// ==== dv/uart_far_side_model.sv ====
// behavioural serial datapath of both ports, feeding status levels
// assumes pclk timing; receive byte advances on each pop
`timescale 1ns/1ps
module uart_far_side_model (
  // clock and reset
  input wire logic                            pclk,
  input wire logic                            presetn,
  // strobes in, status out
  input wire uart_regs_pkg::port_strobe_t [1:0] port_strobe,
  output wire uart_regs_pkg::port_stat_t [1:0]  port_status
);
  // ------------------------------------------------------------
  // per port; port two values offset by one to expose mixups
  // ------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_port
    logic [7:0] rx_count;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rx_count <= 8'h00;
      else if (port_strobe[g].pop_rx) rx_count <= rx_count + 8'h01;
    end
    assign port_status[g].receive_data         = 8'h30 + rx_count + 8'(g);
    assign port_status[g].event_identification = 8'hC1 + 8'(g);
    assign port_status[g].link_status          = 8'h60 + 8'(g);
    assign port_status[g].modem_status         = 8'hB0 + 8'(g);
    assign port_status[g].tx_fifo_level        = 8'h03 + 8'(g);
    assign port_status[g].rx_fifo_level        = 8'h05 + 8'(g);
  end
endmodule : uart_far_side_model

// ==== dv/uart_banked_register_file_tb.sv ====
// apb sequences against the banked register file with a datapath model
// assumes one wait state is not relied on: every wait is bounded
`timescale 1ns/1ps
module uart_banked_register_file_tb;
  localparam logic [7:0] REV = 8'h4D; // arbitrary value
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  uart_regs_pkg::port_stat_t [1:0]   port_status;
  uart_regs_pkg::port_cfg_t [1:0]    port_config;
  uart_regs_pkg::port_strobe_t [1:0] port_strobe;
  int failures, n_checks;
  logic [7:0] pat [7]  = '{8'h00, 8'h80, 8'hC2, 8'hC1, 8'hE0, 8'hE4, 8'hC0};
  logic [7:0] want [7] = '{8'h0B, 8'h3C, 8'h3C, 8'h3C, 8'hC3, 8'hE4, 8'h00};
  logic [7:0] res1 [5] = '{8'h08, 8'h10, 8'h14, 8'h18, 8'h1C};

  uart_banked_register_file #(.MODULE_REVISION_ID(REV)) i_uart_banked_register_file (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_status(port_status), .port_config(port_config), .port_strobe(port_strobe),
    .irq(irq));
  uart_far_side_model i_uart_far_side_model (
    .pclk(pclk), .presetn(presetn), .port_strobe(port_strobe), .port_status(port_status));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task conclude;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      conclude();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
    chk({31'h0, err}, 32'h0);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(rdat, {24'h0, e});
    chk({31'h0, err}, 32'h0);
  endtask : rd

  task wrrd(input logic [7:0] a, input logic [7:0] d);
    wr(a, {24'hFFFFFF, d});
    rd(a, d);
  endtask : wrrd

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    presetn = 1'b0; failures = 0; n_checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h0C, 8'h00);
    wrrd(8'h04, 8'h0B);
    wrrd(8'h10, 8'h12);
    wrrd(8'h1C, 8'h5E);
    rd(8'h14, 8'h60);
    rd(8'h18, 8'hB0);
    rd(8'h00, 8'h30);
    rd(8'h00, 8'h31);
    wr(8'h08, 32'h0000_00C7);
    rd(8'h08, 8'hC1);
    // interrupt: masked-in port one, masked-out port two
    wr(8'h44, 32'h0000_0001);
    wr(8'h00, 32'h0000_00A5);
    @(posedge pclk);
    chk({24'h0, port_strobe[0].tx_data}, 32'hA5);
    chk({31'h0, irq}, 32'h1);
    rd(8'h40, 8'h01);
    wr(8'h40, 32'h0000_0001);
    rd(8'h40, 8'h00);
    chk({31'h0, irq}, 32'h0);
    wr(8'h20, 32'h0000_005A);
    rd(8'h40, 8'h04);
    chk({31'h0, irq}, 32'h0);
    wr(8'h40, 32'h0000_0004);
    // port two apart from port one
    wr(8'h2C, 32'h0000_0080);
    wrrd(8'h24, 8'h77);
    rd(8'h0C, 8'h00);
    rd(8'h04, 8'h0B);
    // bank 1
    wr(8'h0C, 32'h0000_0080);
    wrrd(8'h00, 8'h5A);
    wrrd(8'h04, 8'h3C);
    rd(8'h0C, 8'h80);
    for (int i = 0; i < 5; i++) begin
      wr(res1[i], 32'hFFFF_FFFF);
      rd(res1[i], 8'h00);
    end
    // bank 2
    wr(8'h0C, 32'h0000_00E0);
    wrrd(8'h00, 8'h99);
    wrrd(8'h04, 8'hC3);
    wrrd(8'h08, 8'h81);
    wrrd(8'h10, 8'hB0);
    rd(8'h18, 8'h03);
    rd(8'h1C, 8'h05);
    wr(8'h14, 32'h0000_00FF);
    rd(8'h14, 8'h00);
    // bank 3
    wr(8'h0C, 32'h0000_00E4);
    rd(8'h00, REV);
    rd(8'h08, 8'hC7);
    wr(8'h04, 32'h0000_00FF);
    rd(8'h04, 8'hE4);
    rd(8'h10, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(8'h0C, {24'h0, pat[i]});
      rd(8'h04, want[i]);
    end
    wr(8'h0C, 32'h0);
    rd(8'h1C, 8'h5E);
    xfer(8'h48, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rdat, 32'h0);
    conclude();
  end
endmodule : uart_banked_register_file_tb
